// ---- testbench.sv ----
// self-checking bench for the endpoint control block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] CTL_ADR = {uec_pkg::PAGE_CTL, uec_pkg::OFS_CTL};
    localparam logic [1:0] K_IN = uec_pkg::KIND_IN;
    localparam logic [1:0] K_OUT = uec_pkg::KIND_OUT;
    localparam logic [1:0] K_SU = uec_pkg::KIND_SETUP;
    logic clk = 1'b0, rst = 1'b1, usb_reset = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
    logic tok_v, end_v, end_ok, end_nz, otok_v, hs_v, in_reset, pid, bs;
    logic [3:0] tok_ep, tidx;
    logic hit;
    logic [1:0] tok_kind, otok_code, hs_code;
    logic [7:0] ans, hs;
    int n_errors = 0, total_checks = 0, s;

    uec_endpoint_control uec_endpoint_control_i (.i_clk_sys(clk), .i_sys_rst(rst),
        .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hF), .o_avs_readdata(avs_readdata),
        .o_avs_waitrequest(avs_waitrequest), .i_usb_reset(usb_reset), .i_tok_valid(tok_v), .i_tok_ep(tok_ep),
        .i_tok_kind(tok_kind), .i_end_valid(end_v), .i_end_ok(end_ok), .i_end_nonzero(end_nz),
        .o_tok_valid(otok_v), .o_tok_hit(hit), .o_tok_index(tidx), .o_tok_code(otok_code), .o_tok_data_pid(pid),
        .o_tok_buf_sel(bs), .o_hs_valid(hs_v), .o_hs_code(hs_code), .o_in_reset(in_reset));

    uec_host_model uec_host_model_i (.i_clk_sys(clk), .o_tok_valid(tok_v), .o_tok_ep(tok_ep),
        .o_tok_kind(tok_kind), .o_end_valid(end_v), .o_end_ok(end_ok), .o_end_nonzero(end_nz),
        .i_tok_valid(otok_v), .i_tok_code(otok_code), .i_tok_data_pid(pid), .i_tok_buf_sel(bs),
        .i_hs_valid(hs_v), .i_hs_code(hs_code));

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    // endpoint register word address
    function automatic logic [11:0] adr(input int n, input int b);
        return {(n < 8) ? uec_pkg::PAGE_EP_LO : uec_pkg::PAGE_EP_HI, uec_pkg::OFS_TX + 8'(2 * (n % 8) + b)};
    endfunction : adr

    // token answer with valid set
    function automatic logic [7:0] ansx(input logic [1:0] code);
        return {5'h00, 1'b1, code};
    endfunction : ansx

    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one avalon transfer, held until waitrequest is seen low
    task reg_xfer(input logic wr, input logic [11:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
        int n;
        n = 0;
        @(posedge clk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= addr;
        avs_writedata <= {24'h000000, wdata};
        // waitrequest and read data are taken at the rising edge itself
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_errors++;
            end_of_test();
        end
        rdata = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : reg_xfer

    task reg_wr(input logic [11:0] addr, input logic [7:0] d);
        logic [7:0] r;
        reg_xfer(1'b1, addr, d, r);
    endtask : reg_wr

    task rd_chk(input logic [11:0] addr, input logic [7:0] exp);
        logic [7:0] r;
        reg_xfer(1'b0, addr, 8'h00, r);
        chk(r, exp);
    endtask : rd_chk

    task tk(input logic [3:0] ep, input logic [1:0] kind);
        uec_host_model_i.token(ep, kind, ans, pid, bs);
    endtask : tk

    task en(input logic ok, input logic nz);
        uec_host_model_i.finish_xfer(ok, nz, hs);
    endtask : en

    task end_of_test;
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(adr(0, 0), uec_pkg::TX_RESET);
        rd_chk(adr(15, 1), uec_pkg::RX_RESET);
        reg_wr(12'h100, 8'hFF);
        rd_chk(12'h100, 8'h00);
        // bulk endpoint 1: number set before enabling, toggle initialised
        reg_wr(adr(1, 1), 8'h31);
        reg_wr(adr(1, 0), 8'h30);
        tk(4'h1, K_IN);
        chk(ans, ansx(uec_pkg::EPS_VALID));
        chk({7'h00, pid}, 8'h00);
        en(1'b1, 1'b0);
        rd_chk(adr(1, 0), 8'hE8);
        reg_wr(adr(1, 0), 8'hF0);
        tk(4'h1, K_IN);
        chk(ans, ansx(uec_pkg::EPS_NAK));
        tk(4'h1, K_OUT);
        rd_chk(adr(1, 0), 8'hF8);
        reg_wr(adr(1, 0), 8'h70);
        rd_chk(adr(1, 0), 8'h78);
        reg_wr(adr(1, 0), 8'hF0);
        rd_chk(adr(1, 0), 8'h78);
        tk(4'h1, K_IN);
        chk({7'h00, pid}, 8'h01);
        en(1'b0, 1'b0);
        rd_chk(adr(1, 0), 8'h78);
        // every send state code
        for (s = 0; s < 4; s++) begin
            reg_wr(adr(1, 0), {2'b00, 2'(s), 4'h0});
            tk(4'h1, K_IN);
            chk(ans, ansx(2'(s)));
        end
        // status stage expected on the receive side
        reg_wr(adr(1, 1), 8'hB1);
        tk(4'h1, K_OUT);
        en(1'b1, 1'b1);
        chk(hs, ansx(uec_pkg::HS_STALL));
        rd_chk(adr(1, 0), 8'h30);
        tk(4'h1, K_OUT);
        en(1'b1, 1'b0);
        chk(hs, ansx(uec_pkg::HS_ACK));
        rd_chk(adr(1, 0), 8'hB0);
        rd_chk(adr(1, 1), 8'hE1);
        // control endpoint 2
        reg_wr(adr(2, 1), 8'h32);
        reg_wr(adr(2, 0), 8'h32);
        tk(4'h2, K_SU);
        en(1'b1, 1'b0);
        chk(hs, ansx(uec_pkg::HS_ACK));
        rd_chk(adr(2, 0), 8'hEE);
        tk(4'h2, K_SU);
        chk(ans, ansx(uec_pkg::EPS_DISABLED));
        reg_wr(adr(2, 0), 8'h32);
        tk(4'h2, K_SU);
        chk(ans, ansx(uec_pkg::EPS_DISABLED));
        reg_wr(adr(2, 1), 8'h12);
        tk(4'h2, K_SU);
        chk(ans, ansx(uec_pkg::EPS_VALID));
        en(1'b1, 1'b0);
        rd_chk(adr(2, 0), 8'hEE);
        // isochronous transmit endpoint 3, one direction only
        reg_wr(adr(3, 1), 8'h03);
        reg_wr(adr(3, 0), 8'h31);
        tk(4'h3, K_IN);
        chk({6'h00, pid, bs}, 8'h00);
        en(1'b1, 1'b0);
        rd_chk(adr(3, 0), 8'hF9);
        tk(4'h3, K_IN);
        chk(ans, ansx(uec_pkg::EPS_VALID));
        chk({6'h00, pid, bs}, 8'h01);
        chk({3'h0, hit, tidx}, 8'h13);
        // forced reset holds the interface
        reg_wr(CTL_ADR, 8'h01);
        @(posedge clk);
        @(negedge clk);
        chk({7'h00, in_reset}, 8'h01);
        rd_chk(adr(3, 0), uec_pkg::TX_KEEP_MASK);
        rd_chk(adr(1, 1), 8'h00);
        reg_wr(adr(1, 0), 8'h30);
        rd_chk(adr(1, 0), uec_pkg::TX_KEEP_MASK);
        reg_wr(CTL_ADR, 8'h00);
        // bus reset from the link
        reg_wr(adr(1, 0), 8'h30);
        @(posedge clk);
        usb_reset <= 1'b1;
        repeat (2) @(posedge clk);
        usb_reset <= 1'b0;
        rd_chk(adr(1, 0), 8'h00);
        end_of_test();
    end
endmodule : testbench

// ---- uec_endpoint_control.sv ----
// endpoint control registers and transaction decisions for sixteen endpoints
//
// Chosen here: the Avalon-MM interface to the registers.

// Overview of operation
// RL1: good transaction sets transfer-done; software only clears
// RL2: NAK, STALL, errors leave transfer-done unchanged
// RL3: done pending: NAK all, ignore SETUP
// RL4: resets clear transmit register except transfer-done
// RL5: send DATA0/DATA1 by toggle; flip on ACK
// RL6: SETUP on control endpoint forces toggle one
// RL7: isochronous sends DATA0; toggle flips after packet
// RL8: software initialises toggle before use
// RL9: send state: ignore, STALL, NAK, valid
// RL10: good IN or SETUP sets state NAK
// RL11: isochronous state never changed by hardware
// RL12: software uses only 00 or 11 on isochronous
// RL13: capture last token kind bits
// RL14: token kind frozen while done set
// RL15: control endpoint receive NAK: SETUP unanswered
// RL16: control receive STALL still accepts SETUP
// RL17: isochronous buffer chosen by direction toggle
// RL18: software enables isochronous one direction only
// RL19: status stage expected: nonzero OUT gets STALL
// RL20: sixteen receive registers, cleared by resets
// RL21: software sets endpoint number before enabling
// RL22: forced reset holds interface in reset
// RL23: writing one to transfer-done does nothing
module uec_endpoint_control (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // avalon-mm register slave, word addressed
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // bus reset seen on the link
    input wire logic i_usb_reset,
    // token from the serial engine
    input wire logic i_tok_valid,
    input wire logic [3:0] i_tok_ep,
    input wire logic [1:0] i_tok_kind,
    // end of data stage or handshake stage
    input wire logic i_end_valid,
    input wire logic i_end_ok,
    input wire logic i_end_nonzero,
    // answer to a token
    output logic o_tok_valid,
    output logic o_tok_hit,
    output logic [3:0] o_tok_index,
    output logic [1:0] o_tok_code,
    output logic o_tok_data_pid,
    output logic o_tok_buf_sel,
    // handshake after out or setup data
    output logic o_hs_valid,
    output logic [1:0] o_hs_code,
    // interface held in reset
    output logic o_in_reset
);
    typedef struct packed {
        logic [15:0][7:0] tx;
        logic [15:0][7:0] rx;
        logic forced_bus_reset;
        logic wait_r;
        logic [31:0] rdata;
        logic pend;
        logic [3:0] pidx;
        logic [1:0] pkind;
        logic [1:0] pcode;
        logic tok_v;
        logic tok_hit;
        logic [1:0] tok_code;
        logic tok_pid;
        logic tok_buf;
        logic hs_v;
        logic [1:0] hs_code;
        logic in_rst;
    } uec_state_type;

    uec_state_type s_reg;
    uec_state_type s_next;

    logic rst_any;
    logic f_hit;
    logic [3:0] f_idx;
    logic [3:0] bus_ep;
    logic bus_ep_hit;
    logic bus_ctl_hit;
    logic [7:0] rd_val;
    logic [7:0] t;
    logic [7:0] r;
    logic [1:0] c;
    logic e_iso;

    assign rst_any = i_usb_reset | s_reg.forced_bus_reset;

    // next state: bus slave, endpoint lookup, token and end handling
    always_comb begin
        s_next = s_reg;
        s_next.tok_v = 1'b0;
        s_next.hs_v = 1'b0;
        s_next.in_rst = rst_any;
        t = 8'h00;
        r = 8'h00;
        c = uec_pkg::EPS_DISABLED;
        e_iso = 1'b0;
        // register decode
        bus_ep = {(i_avs_address[11:8] == uec_pkg::PAGE_EP_HI), i_avs_address[3:1]};
        bus_ep_hit = ((i_avs_address[11:8] == uec_pkg::PAGE_EP_LO) ||
                      (i_avs_address[11:8] == uec_pkg::PAGE_EP_HI)) &&
                     (i_avs_address[7:4] == uec_pkg::OFS_TX[7:4]);
        bus_ctl_hit = (i_avs_address[11:8] == uec_pkg::PAGE_CTL) && (i_avs_address[7:0] == uec_pkg::OFS_CTL);
        rd_val = 8'h00;
        if (bus_ep_hit) begin
            rd_val = i_avs_address[0] ? s_reg.rx[bus_ep] : s_reg.tx[bus_ep];
        end else if (bus_ctl_hit) begin
            rd_val = {7'h00, s_reg.forced_bus_reset};
        end
        // one wait cycle, then the request completes
        s_next.wait_r = (i_avs_read | i_avs_write) ? ~s_reg.wait_r : 1'b1;
        if ((i_avs_read | i_avs_write) && s_reg.wait_r) begin
            s_next.rdata = {24'h000000, rd_val};
        end
        if (i_avs_write && !s_reg.wait_r && i_avs_byteenable[0]) begin
            if (bus_ctl_hit) begin
                s_next.forced_bus_reset = i_avs_writedata[uec_pkg::CTL_FORCED_BUS_RESET_BIT]; // [RL22]
            end else if (bus_ep_hit && !rst_any) begin
                if (i_avs_address[0]) begin
                    s_next.rx[bus_ep] = i_avs_writedata[7:0]; // [RL20]
                end else begin
                    // kind bits are read-only; done bit only clears
                    s_next.tx[bus_ep][6:4] = i_avs_writedata[6:4];
                    s_next.tx[bus_ep][1:0] = i_avs_writedata[1:0];
                    if (!i_avs_writedata[uec_pkg::TX_DONE_BIT]) begin
                        s_next.tx[bus_ep][uec_pkg::TX_DONE_BIT] = 1'b0; // [RL23]
                    end
                end
            end
        end
        // find lowest endpoint whose number matches and direction is enabled
        f_hit = 1'b0;
        f_idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if ((s_reg.rx[i][3:0] == i_tok_ep) &&
                (((i_tok_kind == uec_pkg::KIND_IN) && (s_reg.tx[i][5:4] != uec_pkg::EPS_DISABLED)) ||
                 ((i_tok_kind != uec_pkg::KIND_IN) && (s_reg.rx[i][5:4] != uec_pkg::EPS_DISABLED)))) begin
                f_hit = 1'b1;
                f_idx = i[3:0];
            end
        end
        // end of a transaction on the pending endpoint
        if (i_end_valid && s_reg.pend && !rst_any) begin
            s_next.pend = 1'b0;
            t = s_next.tx[s_reg.pidx];
            r = s_next.rx[s_reg.pidx];
            e_iso = t[uec_pkg::TX_ISO_BIT];
            if (s_reg.pkind == uec_pkg::KIND_IN) begin
                if (s_reg.pcode == uec_pkg::EPS_VALID) begin
                    if (e_iso) begin
                        t[uec_pkg::TX_TOG_BIT] = ~t[uec_pkg::TX_TOG_BIT]; // [RL7] [RL17]
                        t[uec_pkg::TX_DONE_BIT] = 1'b1; // [RL11]
                    end else if (i_end_ok) begin
                        t[uec_pkg::TX_TOG_BIT] = ~t[uec_pkg::TX_TOG_BIT]; // [RL5]
                        t[uec_pkg::TX_DONE_BIT] = 1'b1; // [RL1]
                        t[5:4] = uec_pkg::EPS_NAK; // [RL10]
                    end
                end
            end else if (s_reg.pkind == uec_pkg::KIND_SETUP) begin
                if ((s_reg.pcode == uec_pkg::EPS_VALID) && i_end_ok) begin
                    t[uec_pkg::TX_DONE_BIT] = 1'b1; // [RL1] [RL16]
                    t[5:4] = uec_pkg::EPS_NAK; // [RL10]
                    r[5:4] = uec_pkg::EPS_NAK;
                    s_next.hs_v = 1'b1;
                    s_next.hs_code = uec_pkg::HS_ACK;
                end
            end else if (e_iso) begin
                // isochronous out: no handshake, buffers swap on each good packet
                if ((s_reg.pcode == uec_pkg::EPS_VALID) && i_end_ok) begin
                    r[uec_pkg::RX_TOG_BIT] = ~r[uec_pkg::RX_TOG_BIT]; // [RL17]
                    t[uec_pkg::TX_DONE_BIT] = 1'b1;
                end
            end else begin
                unique case (s_reg.pcode)
                    uec_pkg::EPS_DISABLED: begin
                        s_next.hs_v = 1'b0;
                    end
                    uec_pkg::EPS_STALL: begin
                        s_next.hs_v = 1'b1;
                        s_next.hs_code = uec_pkg::HS_STALL;
                    end
                    uec_pkg::EPS_NAK: begin
                        s_next.hs_v = 1'b1; // [RL2] [RL3]
                        s_next.hs_code = uec_pkg::HS_NAK;
                    end
                    uec_pkg::EPS_VALID: begin
                        if (r[uec_pkg::RX_STATUS_BIT] && i_end_nonzero) begin
                            s_next.hs_v = 1'b1; // [RL19]
                            s_next.hs_code = uec_pkg::HS_STALL;
                        end else if (i_end_ok) begin
                            r[uec_pkg::RX_TOG_BIT] = ~r[uec_pkg::RX_TOG_BIT];
                            r[5:4] = uec_pkg::EPS_NAK;
                            t[uec_pkg::TX_DONE_BIT] = 1'b1; // [RL1]
                            s_next.hs_v = 1'b1;
                            s_next.hs_code = uec_pkg::HS_ACK;
                        end
                    end
                endcase
            end
            s_next.tx[s_reg.pidx] = t;
            s_next.rx[s_reg.pidx] = r;
        end
        // token lookup and answer
        if (i_tok_valid && !rst_any) begin
            t = s_next.tx[f_idx];
            r = s_next.rx[f_idx];
            e_iso = t[uec_pkg::TX_ISO_BIT];
            if (!f_hit || (i_tok_kind == 2'b01)) begin
                c = uec_pkg::EPS_DISABLED;
            end else if (i_tok_kind == uec_pkg::KIND_IN) begin
                c = t[5:4]; // [RL9]
                if (!e_iso && t[uec_pkg::TX_DONE_BIT] && (c == uec_pkg::EPS_VALID)) begin
                    c = uec_pkg::EPS_NAK; // [RL3]
                end
            end else if (i_tok_kind == uec_pkg::KIND_OUT) begin
                c = r[5:4];
                if (!e_iso && t[uec_pkg::TX_DONE_BIT] && (c == uec_pkg::EPS_VALID)) begin
                    c = uec_pkg::EPS_NAK; // [RL3]
                end
            end else if (t[uec_pkg::TX_CTRL_BIT] && !e_iso && !t[uec_pkg::TX_DONE_BIT] &&
                         (r[5:4] != uec_pkg::EPS_NAK)) begin
                c = uec_pkg::EPS_VALID; // [RL15] [RL16]
            end else begin
                c = uec_pkg::EPS_DISABLED; // [RL3]
            end
            if (f_hit && (i_tok_kind != 2'b01) && !t[uec_pkg::TX_DONE_BIT]) begin
                t[3:2] = i_tok_kind; // [RL13] [RL14]
            end
            if ((i_tok_kind == uec_pkg::KIND_SETUP) && (c == uec_pkg::EPS_VALID)) begin
                t[uec_pkg::TX_TOG_BIT] = 1'b1; // [RL6]
                r[uec_pkg::RX_TOG_BIT] = 1'b0;
            end
            s_next.tx[f_idx] = t;
            s_next.rx[f_idx] = r;
            s_next.tok_v = 1'b1;
            s_next.tok_hit = f_hit;
            s_next.tok_code = c;
            s_next.tok_pid = e_iso ? 1'b0 : t[uec_pkg::TX_TOG_BIT]; // [RL5] [RL7]
            s_next.tok_buf = (i_tok_kind == uec_pkg::KIND_IN) ? t[uec_pkg::TX_TOG_BIT] : r[uec_pkg::RX_TOG_BIT];
            s_next.pend = f_hit && (c != uec_pkg::EPS_DISABLED);
            s_next.pidx = f_idx;
            s_next.pkind = i_tok_kind;
            s_next.pcode = c;
        end
        // bus reset or forced reset: clear all but the done flags
        if (rst_any) begin
            for (int i = 0; i < 16; i++) begin
                s_next.tx[i] = s_reg.tx[i] & uec_pkg::TX_KEEP_MASK; // [RL4] [RL22]
                s_next.rx[i] = uec_pkg::RX_RESET; // [RL20]
            end
            s_next.pend = 1'b0;
        end
    end

    // state register
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            s_reg <= '0;
            s_reg.wait_r <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign o_avs_readdata = s_reg.rdata;
    assign o_avs_waitrequest = s_reg.wait_r;
    assign o_tok_valid = s_reg.tok_v;
    assign o_tok_hit = s_reg.tok_hit;
    assign o_tok_index = s_reg.pidx;
    assign o_tok_code = s_reg.tok_code;
    assign o_tok_data_pid = s_reg.tok_pid;
    assign o_tok_buf_sel = s_reg.tok_buf;
    assign o_hs_valid = s_reg.hs_v;
    assign o_hs_code = s_reg.hs_code;
    assign o_in_reset = s_reg.in_rst;

    // per-endpoint checks
    for (genvar k = 0; k < 16; k++) begin : g_chk
        done_set_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL1]
            $rose(s_reg.tx[k][7]) |-> $past(i_end_valid && s_reg.pend && (s_reg.pidx == k)))
            else $error("done flag set without a finished transaction");
        done_write_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL23]
            (!s_reg.tx[k][7] && !i_end_valid) |=> !s_reg.tx[k][7])
            else $error("done flag set by software");
        reset_clear_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL4]
            rst_any |=> (s_reg.tx[k][6:0] == 7'h00) && (s_reg.rx[k] == 8'h00) && $stable(s_reg.tx[k][7]))
            else $error("endpoint registers not cleared by reset");
        kind_frozen_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL14]
            (s_reg.tx[k][7] && !rst_any) |=> (s_reg.tx[k][3:2] == $past(s_reg.tx[k][3:2])))
            else $error("token kind changed while done flag set");
    end

    busy_nak_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL3]
        (i_tok_valid && !rst_any && f_hit && (i_tok_kind == uec_pkg::KIND_IN) && s_reg.tx[f_idx][7] &&
         !s_reg.tx[f_idx][0] && (s_reg.tx[f_idx][5:4] == uec_pkg::EPS_VALID)) |=>
        (o_tok_valid && (o_tok_code == uec_pkg::EPS_NAK)))
        else $error("busy endpoint did not answer NAK");
    data_pid_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL5]
        (o_tok_valid && (s_reg.pkind == uec_pkg::KIND_IN) && (o_tok_code == uec_pkg::EPS_VALID)) |->
        (o_tok_data_pid == (!s_reg.tx[s_reg.pidx][0] && s_reg.tx[s_reg.pidx][6])))
        else $error("wrong data pid for IN");
    setup_tog_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL6]
        (o_tok_valid && (s_reg.pkind == uec_pkg::KIND_SETUP) && (o_tok_code == uec_pkg::EPS_VALID)) |->
        s_reg.tx[s_reg.pidx][6])
        else $error("SETUP did not force send toggle");
    in_done_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL10]
        (i_end_valid && i_end_ok && s_reg.pend && !rst_any && (s_reg.pkind == uec_pkg::KIND_IN) &&
         (s_reg.pcode == uec_pkg::EPS_VALID) && !s_reg.tx[s_reg.pidx][0]) |=>
        (s_reg.tx[$past(s_reg.pidx)][5:4] == uec_pkg::EPS_NAK) &&
        (s_reg.tx[$past(s_reg.pidx)][6] != $past(s_reg.tx[s_reg.pidx][6])))
        else $error("good IN did not set NAK and flip toggle");
    iso_keep_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL11]
        (i_end_valid && s_reg.pend && !rst_any && s_reg.tx[s_reg.pidx][0] && !i_avs_write && !i_tok_valid) |=>
        (s_reg.tx[$past(s_reg.pidx)][5:4] == $past(s_reg.tx[s_reg.pidx][5:4])))
        else $error("isochronous state changed by hardware");
    setup_mute_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL15]
        (i_tok_valid && !rst_any && f_hit && (i_tok_kind == uec_pkg::KIND_SETUP) &&
         (s_reg.rx[f_idx][5:4] == uec_pkg::EPS_NAK)) |=> (o_tok_code == uec_pkg::EPS_DISABLED) ##1 !o_hs_valid)
        else $error("SETUP answered on NAK control endpoint");
    status_stall_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL19]
        (i_end_valid && s_reg.pend && !rst_any && (s_reg.pkind == uec_pkg::KIND_OUT) &&
         (s_reg.pcode == uec_pkg::EPS_VALID) && !s_reg.tx[s_reg.pidx][0] && s_reg.rx[s_reg.pidx][7] &&
         i_end_nonzero) |=>
        (o_hs_valid && (o_hs_code == uec_pkg::HS_STALL)))
        else $error("nonzero OUT in status stage not stalled");
    fail_keep_a : assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [RL2]
        (i_end_valid && !i_end_ok && s_reg.pend && !s_reg.tx[s_reg.pidx][0] && !s_reg.tx[s_reg.pidx][7]) |=>
        !s_reg.tx[$past(s_reg.pidx)][7])
        else $error("failed transaction set done flag");
endmodule : uec_endpoint_control

// ---- uec_host_model.sv ----
// host controller side model: issues tokens and transaction ends, samples answers
module uec_host_model (
    // clock
    input wire logic i_clk_sys,
    // token and end strobes into the block
    output logic o_tok_valid,
    output logic [3:0] o_tok_ep,
    output logic [1:0] o_tok_kind,
    output logic o_end_valid,
    output logic o_end_ok,
    output logic o_end_nonzero,
    // answers from the block
    input wire logic i_tok_valid,
    input wire logic [1:0] i_tok_code,
    input wire logic i_tok_data_pid,
    input wire logic i_tok_buf_sel,
    input wire logic i_hs_valid,
    input wire logic [1:0] i_hs_code
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle strobes from time zero
    initial begin
        o_tok_valid = 1'b0;
        o_tok_ep = 4'h0;
        o_tok_kind = 2'h0;
        o_end_valid = 1'b0;
        o_end_ok = 1'b0;
        o_end_nonzero = 1'b0;
    end

    // one token pulse; answer sampled in the cycle after it stands
    task token(input logic [3:0] ep, input logic [1:0] kind, output logic [7:0] ans, output logic pid,
               output logic bsel);
        @(posedge i_clk_sys);
        o_tok_valid <= 1'b1;
        o_tok_ep <= ep;
        o_tok_kind <= kind;
        @(posedge i_clk_sys);
        o_tok_valid <= 1'b0;
        o_tok_ep <= ~ep; // released lines do not keep the last value
        o_tok_kind <= ~kind;
        @(negedge i_clk_sys);
        ans = {5'h00, i_tok_valid, i_tok_code};
        pid = i_tok_data_pid;
        bsel = i_tok_buf_sel;
    endtask : token

    // end of data or handshake stage, always after its token
    task finish_xfer(input logic ok, input logic nonzero, output logic [7:0] hs);
        @(posedge i_clk_sys);
        o_end_valid <= 1'b1;
        o_end_ok <= ok;
        o_end_nonzero <= nonzero;
        @(posedge i_clk_sys);
        o_end_valid <= 1'b0;
        o_end_ok <= ~ok;
        o_end_nonzero <= ~nonzero;
        @(negedge i_clk_sys);
        hs = {5'h00, i_hs_valid, i_hs_code};
    endtask : finish_xfer
endmodule : uec_host_model

// ---- uec_pkg.sv ----
// constants and encodings shared by the endpoint control block
package uec_pkg;
    // register index = {page, offset}; byte address = 4 * index
    localparam logic [3:0] PAGE_EP_LO = 4'h4;
    localparam logic [3:0] PAGE_EP_HI = 4'h5;
    localparam logic [3:0] PAGE_CTL = 4'hF;
    localparam logic [7:0] OFS_TX = 8'hF0;
    localparam logic [7:0] OFS_RX = 8'hF1;
    localparam logic [7:0] OFS_CTL = 8'hFC;
    // reset values
    localparam logic [7:0] TX_RESET = 8'h00;
    localparam logic [7:0] RX_RESET = 8'h00;
    localparam logic [7:0] TX_KEEP_MASK = 8'h80;
    // transmit control fields
    localparam int TX_DONE_BIT = 7;
    localparam int TX_TOG_BIT = 6;
    localparam int TX_STATE_LSB = 4;
    localparam int TX_KIND_LSB = 2;
    localparam int TX_CTRL_BIT = 1;
    localparam int TX_ISO_BIT = 0;
    // receive control fields
    localparam int RX_STATUS_BIT = 7;
    localparam int RX_TOG_BIT = 6;
    localparam int RX_STATE_LSB = 4;
    localparam int RX_NUM_LSB = 0;
    // interface control fields
    localparam int CTL_FORCED_BUS_RESET_BIT = 0;
    // endpoint direction states, also used as token answer codes
    typedef enum logic [1:0] {
        EPS_DISABLED = 2'b00,
        EPS_STALL = 2'b01,
        EPS_NAK = 2'b10,
        EPS_VALID = 2'b11
    } uec_epstate_type;
    // upper two bits of token pids
    localparam logic [1:0] KIND_OUT = 2'b00;
    localparam logic [1:0] KIND_IN = 2'b10;
    localparam logic [1:0] KIND_SETUP = 2'b11;
    // handshakes driven after an out or setup data stage
    localparam logic [1:0] HS_STALL = 2'b01;
    localparam logic [1:0] HS_NAK = 2'b10;
    localparam logic [1:0] HS_ACK = 2'b11;
endpackage : uec_pkg
